// ### sim/codec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side codec: takes words, sends words
// ----------------------------------------
module codec_model (
  input  wire logic             clock_i,
  input  wire ssi_pkg::tx_pins_t tx_i,
  input  wire logic             gated_i,
  input  wire logic [4:0]       nbits_i,
  output var  ssi_pkg::rx_pins_t rx_o,
  output var  logic [23:0]      word_o,
  output var  logic [7:0]       words_o,
  output var  logic [15:0]      edges_o,
  output var  logic [15:0]      space_o
);
  import ssi_pkg::*;
  logic        sck_q = 1'b0;       // Last clock sample
  logic [4:0]  cnt   = 5'h00;      // Bits taken so far
  logic [23:0] sh    = 24'h000000; // Shift register
  logic [15:0] cyc   = 16'h0000;   // Free cycle count
  logic [15:0] start = 16'h0000;   // Cycle of last word start
  logic [23:0] nxt;                // Word with new bit
  initial
  begin
    rx_o    = '0;
    word_o  = '0;
    words_o = '0;
    edges_o = '0;
    space_o = '0;
  end
  // Capture on rising bit clock, MSB first
  always @(posedge clock_i)
  begin
    sck_q <= tx_i.sck;
    cyc   <= cyc + 16'h0001;
    if (tx_i.sck && !sck_q)
    begin
      edges_o <= edges_o + 16'h0001;
      nxt = {(cnt == 5'h00) ? 23'h0 : sh[22:0], tx_i.txd};
      // Gated: a pulse alone opens a word
      if (cnt != 5'h00 || tx_i.fs || gated_i)
      begin
        if (cnt == 5'h00)
        begin
          space_o <= cyc - start;
          start   <= cyc;
        end
        if (cnt + 5'h01 == nbits_i)
        begin
          word_o  <= nxt;
          words_o <= words_o + 8'h01;
          cnt     <= 5'h00;
        end
        else
        begin
          sh  <= nxt;
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
  // Clock runs only inside the frame; data left inverted after
  task automatic send_word(input logic [23:0] w, input int n);
    int i;
    begin
      #7;
      for (i = n - 1; i >= 0; i--)
      begin
        rx_o.rxd = w[i];
        rx_o.fs  = (i == n - 1);
        #200 rx_o.sck = 1'b1;
        #200 rx_o.sck = 1'b0;
      end
      rx_o.fs  = 1'b0;
      rx_o.rxd = ~rx_o.rxd;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/ssi_on_demand_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_on_demand_tb;
  import ssi_pkg::*;
  logic        clock_i     = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [15:0] addr_i      = 16'h0000;
  logic [23:0] wdata_i     = 24'h000000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic [23:0] rdata_o;
  rx_pins_t    rx_pins;
  tx_pins_t    tx_pins;
  logic        gated       = 1'b0;
  logic [4:0]  nbits       = 5'h08;
  logic [23:0] word;
  logic [7:0]  words;
  logic [15:0] edges;
  logic [15:0] space;
  logic [23:0] d;
  logic [15:0] e0;
  int          n_fail      = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          k;
  always #25 clock_i = ~clock_i;
  ssi_on_demand uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_pins_i(rx_pins), .tx_pins_o(tx_pins));
  codec_model partner (.clock_i(clock_i), .tx_i(tx_pins), .gated_i(gated),
    .nbits_i(nbits), .rx_o(rx_pins), .word_o(word), .words_o(words),
    .edges_o(edges), .space_o(space));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [23:0] v);
    begin
      @(posedge clock_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clock_i);
      wr_i    <= 1'b0;
    end
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [23:0] v);
    begin
      @(posedge clock_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i   <= 1'b0;
      #1 v = rdata_o;
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [23:0] exp);
    logic [23:0] v;
    begin
      rd(a, v);
      check(v, exp);
    end
  endtask
  // Bounded polls, so a stuck flag ends in a mismatch
  task automatic wait_tde;
    logic [23:0] s;
    int i;
    begin
      s = 24'h000000;
      for (i = 0; i < 400 && s[STAT_TDE] !== 1'b1; i++)
        rd(A_STAT, s);
      check({23'h0, s[STAT_TDE]}, 24'h000001);
    end
  endtask
  task automatic wait_words(input logic [7:0] n);
    int i;
    begin
      for (i = 0; i < 3000 && words !== n; i++)
        @(posedge clock_i);
      check({16'h0, words}, {16'h0, n});
    end
  endtask
  task automatic tally_and_finish;
    begin
      if (n_fail == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hang guard, far above the expected run
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(A_STAT, 24'h000040);
    rdc(16'h0000, 24'h000000);
    wr(A_STAT, 24'hFFFFFF);
    rdc(A_STAT, 24'h000040);
    wr(A_PDIR, 24'h00A5C3);
    rdc(A_PDIR, 24'h00A5C3);
    // Continuous clock, divide ratio not yet zero
    wr(A_CTLA, 24'h000101);
    wr(A_CTLB, 24'h003830);
    wr(A_PCC, 24'h000100);
    repeat (100) @(posedge clock_i);
    check({16'h0, words}, 24'h0);
    check({22'h0, tx_pins.fs_oe, tx_pins.sck_oe}, 24'h3);
    wr(A_DATA, 24'h0000A5);
    rdc(A_STAT, 24'h000000);
    wr(A_DATA, 24'h00003C);
    repeat (100) @(posedge clock_i);
    check({16'h0, words}, 24'h0);
    wr(A_CTLA, 24'h000001);
    wait_words(8'h01);
    wait_tde;
    rdc(A_STAT, 24'h000040);
    repeat (200) @(posedge clock_i);
    check({16'h0, words}, 24'h1);
    check(word, 24'h0000A5);
    // Each word length, two words back to back
    for (k = 0; k < 4; k++)
    begin
      nbits = (k == 3) ? 5'h18 : 5'(8 + 4 * k);
      d = 24'hC35A96 & ((24'h1 << nbits) - 24'h1);
      wr(A_CTLA, {9'h0, 2'(k), 13'h0001});
      e0 = {8'h0, words};
      wr(A_DATA, ~d);
      wait_tde;
      wr(A_DATA, d);
      wait_words(e0[7:0] + 8'h02);
      check(word, d);
      check({23'h0, space >= 16'(4 * (nbits + 2))}, 24'h1);
    end
    // Gated clock: pulses only while a word moves
    nbits = 5'h08;
    wr(A_CTLA, 24'h000001);
    wr(A_CTLB, 24'h003C30);
    repeat (20) @(posedge clock_i);
    gated = 1'b1;
    e0 = edges;
    wr(A_DATA, 24'h000081);
    wait_tde;
    wr(A_DATA, 24'h000042);
    repeat (300) @(posedge clock_i);
    check({8'h0, edges - e0}, 24'h000010);
    check(word, 24'h000042);
    // Receive beside a running transmitter, clock from the pins
    gated = 1'b0;
    wr(A_CTLB, 24'h003830);
    partner.send_word(24'h00005A, 8);
    repeat (6) @(posedge clock_i);
    rdc(A_STAT, 24'h0000C0);
    rdc(A_DATA, 24'h00005A);
    rdc(A_STAT, 24'h000040);
    partner.send_word(24'h000011, 8);
    partner.send_word(24'h000022, 8);
    repeat (6) @(posedge clock_i);
    rdc(A_STAT, 24'h0000C0);
    rdc(A_DATA, 24'h000022);
    // Receive only, pins as inputs, data pin released
    wr(A_CTLB, 24'h001800);
    repeat (4) @(posedge clock_i);
    check({21'h0, tx_pins.txd_oe, tx_pins.fs_oe, tx_pins.sck_oe}, 24'h0);
    partner.send_word(24'h000077, 8);
    repeat (6) @(posedge clock_i);
    rdc(A_DATA, 24'h000077);
    // Synchronous gated: receiver clocks on the loaded word
    // Receive line rests low after the last word, so zeros come in
    wr(A_CTLB, 24'h003E30);
    wr(A_DATA, 24'h0000C3);
    repeat (12) @(posedge clock_i);
    check({23'h0, tx_pins.txd_oe}, 24'h000001);
    repeat (48) @(posedge clock_i);
    check(word, 24'h0000C3);
    rdc(A_STAT, 24'h0000C0);
    rdc(A_DATA, 24'h000000);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ### verilog/ssi_on_demand.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_on_demand (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic [15:0]           addr_i,
  input  wire logic [23:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output var  logic [23:0]           rdata_o,
  input  wire ssi_pkg::rx_pins_t     rx_pins_i,
  output var  ssi_pkg::tx_pins_t     tx_pins_o
);
  import ssi_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [23:0] pcc_ff;      // port_c_control
  logic [23:0] pdir_ff;     // port_c_direction
  logic [23:0] pdat_ff;     // port_c_pin_data
  logic [23:0] ctla_ff;     // serial_control_a
  logic [23:0] ctlb_ff;     // serial_control_b
  logic [23:0] hold_ff;     // Pending transmit word
  logic [23:0] rx_data_ff;  // Last received word
  logic        tde_ff;      // transmit_empty_flag
  logic        rdf_ff;      // receive_full_flag

  // Decoded strobes
  logic wr_data;
  logic rd_data;
  assign wr_data = wr_i && (addr_i == A_DATA);
  assign rd_data = rd_i && (addr_i == A_DATA);

  // Decoded mode
  logic       port_on;
  logic       on_demand;
  logic       gck;
  logic       syn;
  logic [4:0] wl_bits;
  assign port_on   = pcc_ff[PCC_ON];
  assign on_demand = ctlb_ff[CTLB_NET]
                     && (ctla_ff[CTLA_DIV_LSB +: 5] == DIV_OND);
  assign gck       = ctlb_ff[CTLB_GCK];
  assign syn       = ctlb_ff[CTLB_SYN];
  assign wl_bits   = word_bits(ctla_ff[CTLA_WL_LSB +: 2]);

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pcc_ff  <= REG_RST;
      pdir_ff <= REG_RST;
      pdat_ff <= REG_RST;
      ctla_ff <= REG_RST;
      ctlb_ff <= REG_RST;
    end
    else if (wr_i)
    begin
      // Status is read-only, data handled apart
      case (addr_i)
        A_PCC:   pcc_ff  <= wdata_i;
        A_PDIR:  pdir_ff <= wdata_i;
        A_PDAT:  pdat_ff <= wdata_i;
        A_CTLA:  ctla_ff <= wdata_i;
        A_CTLB:  ctlb_ff <= wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Bit clock generator
  // ----------------------------------------
  logic [7:0] div_cnt_ff; // Half period counter
  logic       sck_int_ff; // Free running bit clock
  logic       tick;
  logic       fall_tick;  // Transmit side changes here
  assign tick      = port_on && (div_cnt_ff == ctla_ff[CTLA_PRE_LSB +: 8]);
  assign fall_tick = tick && sck_int_ff;

  // Divider stops with the port to keep phase known
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !port_on)
    begin
      div_cnt_ff <= 8'h00;
      sck_int_ff <= 1'b0;
    end
    else if (tick)
    begin
      div_cnt_ff <= 8'h00;
      sck_int_ff <= ~sck_int_ff;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // Transmit state machine
  // ----------------------------------------
  tx_state_t   tx_state_ff;
  logic [23:0] tx_sh_ff;   // Word being shifted
  logic [4:0]  tx_cnt_ff;  // Bit index, counts down
  logic [1:0]  gap_ff;     // Idle bit clocks left
  logic        tx_fs_ff;   // Frame sync, first bit only
  logic        tx_run;
  logic        tx_load;    // Hold moves into shifter
  logic        gap_done;
  assign tx_run   = port_on && on_demand && ctlb_ff[CTLB_TE];
  assign gap_done = (tx_state_ff == TX_IDLE)
                    || ((tx_state_ff == TX_GAP) && (gap_ff == 2'h0));
  // A word leaves only after software wrote one
  assign tx_load  = tx_run && fall_tick && gap_done && !tde_ff;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !tx_run)
    begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff    <= REG_RST;
      tx_cnt_ff   <= 5'h00;
      gap_ff      <= 2'h0;
      tx_fs_ff    <= 1'b0;
    end
    else if (tx_load)
    begin
      // Sync rides the first bit of the word
      tx_state_ff <= TX_SHIFT;
      tx_sh_ff    <= hold_ff;
      tx_cnt_ff   <= wl_bits - 5'h01;
      tx_fs_ff    <= 1'b1;
    end
    else if (fall_tick)
    begin
      tx_fs_ff <= 1'b0;
      case (tx_state_ff)
        TX_SHIFT:
        begin
          if (tx_cnt_ff == 5'h00)
          begin
            // Gap keeps sync low and gated clock off
            tx_state_ff <= TX_GAP;
            gap_ff      <= GAP_BITS - 2'h1;
          end
          else
          begin
            tx_cnt_ff <= tx_cnt_ff - 5'h01;
          end
        end
        TX_GAP:
        begin
          if (gap_ff == 2'h0)
            tx_state_ff <= TX_IDLE;
          else
            gap_ff <= gap_ff - 2'h1;
        end
        TX_IDLE: ;
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit hold register and empty flag
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      hold_ff <= REG_RST;
      tde_ff  <= 1'b1;
    end
    else if (wr_data && tde_ff)
    begin
      // Second write while full is dropped
      hold_ff <= wdata_i;
      tde_ff  <= 1'b0;
    end
    else if (tx_load)
    begin
      tde_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Receive pin synchronisers
  // ----------------------------------------
  rx_pins_t rx_s1_ff; // First stage, read by second only
  rx_pins_t rx_s2_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rx_s1_ff <= '0;
      rx_s2_ff <= '0;
    end
    else
    begin
      rx_s1_ff <= rx_pins_i;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic        rx_clk;     // Selected receive clock
  logic        rx_fs;      // Selected receive sync
  logic        rx_clk_q_ff;
  logic        rx_busy_ff;
  logic [23:0] rx_sh_ff;
  logic [4:0]  rx_cnt_ff;  // Bits still to come
  logic        rx_run;
  logic        rx_rise;
  logic        rx_done;
  // Own clocks only in synchronous mode; full duplex needs pins
  assign rx_clk  = syn ? (sck_int_ff && (!gck || tx_state_ff == TX_SHIFT))
                       : rx_s2_ff.sck;
  assign rx_fs   = syn ? tx_fs_ff : rx_s2_ff.fs;
  assign rx_run  = port_on && on_demand && ctlb_ff[CTLB_RE];
  assign rx_rise = rx_run && rx_clk && !rx_clk_q_ff;
  assign rx_done = rx_rise && rx_busy_ff && (rx_cnt_ff == 5'h01);

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rx_clk_q_ff <= 1'b0;
    else
      rx_clk_q_ff <= rx_clk;
  end

  // Gated: any clock starts a word; continuous: sync must be high
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || !rx_run)
    begin
      rx_busy_ff <= 1'b0;
      rx_sh_ff   <= REG_RST;
      rx_cnt_ff  <= 5'h00;
    end
    else if (rx_rise)
    begin
      rx_sh_ff <= {rx_sh_ff[22:0], rx_s2_ff.rxd};
      if (!rx_busy_ff && (gck || rx_fs))
      begin
        rx_busy_ff <= 1'b1;
        rx_cnt_ff  <= wl_bits - 5'h01;
      end
      else if (rx_busy_ff)
      begin
        rx_cnt_ff  <= rx_cnt_ff - 5'h01;
        rx_busy_ff <= (rx_cnt_ff != 5'h01);
      end
    end
  end

  // No overrun: a new word simply replaces the old
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rx_data_ff <= REG_RST;
      rdf_ff     <= 1'b0;
    end
    else if (rx_done)
    begin
      // Set wins over a read in the same cycle
      rx_data_ff <= {rx_sh_ff[22:0], rx_s2_ff.rxd} & ~(24'hFFFFFF << wl_bits);
      rdf_ff     <= 1'b1;
    end
    else if (rd_data)
    begin
      rdf_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data, valid the cycle after rd_i
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rdata_o <= REG_RST;
    else if (rd_i)
    begin
      case (addr_i)
        A_PCC:   rdata_o <= pcc_ff;
        A_PDIR:  rdata_o <= pdir_ff;
        A_PDAT:  rdata_o <= pdat_ff;
        A_CTLA:  rdata_o <= ctla_ff;
        A_CTLB:  rdata_o <= ctlb_ff;
        A_STAT:  rdata_o <= ({23'h0, rdf_ff} << STAT_RDF)
                            | ({23'h0, tde_ff} << STAT_TDE);
        A_DATA:  rdata_o <= rx_data_ff;
        default: rdata_o <= REG_RST; // Unmapped reads zero
      endcase
    end
    else
      rdata_o <= REG_RST;
  end

  // ----------------------------------------
  // Pin drivers, one register stage
  // ----------------------------------------
  // Clock and sync directions follow their control bits while the port is on; data pin drives only while shifting
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      tx_pins_o <= '0;
    else
    begin
      tx_pins_o.sck    <= sck_int_ff && (!gck || tx_state_ff == TX_SHIFT);
      tx_pins_o.sck_oe <= port_on && ctlb_ff[CTLB_BIT_CLOCK_DIRECTION];
      tx_pins_o.fs     <= tx_fs_ff;
      tx_pins_o.fs_oe  <= port_on && ctlb_ff[CTLB_FSD];
      tx_pins_o.txd    <= (tx_state_ff == TX_SHIFT) && tx_sh_ff[tx_cnt_ff];
      tx_pins_o.txd_oe <= tx_run && (tx_state_ff == TX_SHIFT);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_write_taken;
    wr_data && tde_ff;
  endsequence
  sequence s_load;
    tx_load;
  endsequence
  sequence s_shift_start;
    $rose(tx_state_ff == TX_SHIFT);
  endsequence

  a_sync_needs_word: assert property ($rose(tx_fs_ff) |-> !$past(tde_ff))
    else $error("frame sync without pending word");
  a_sync_first_bit: assert property (
    tx_fs_ff |-> tx_state_ff == TX_SHIFT && tx_cnt_ff == wl_bits - 5'h01)
    else $error("frame sync not on first bit");
  // A word may only begin while the hold register is full
  a_write_starts: assert property (s_shift_start |-> !$past(tde_ff))
    else $error("word started without a write");
  a_single_pending: assert property (wr_data && !tde_ff |=> $stable(hold_ff))
    else $error("second word overwrote hold");
  a_load_sets_empty: assert property (s_load |=> tde_ff && tx_fs_ff)
    else $error("load did not set empty");
  a_write_clears: assert property (s_write_taken |=> !tde_ff)
    else $error("write did not clear empty");
  a_full_on_word: assert property (rx_done |=> rdf_ff ##1 rdf_ff || $past(rd_data))
    else $error("receive full not set");
  a_gap_quiet: assert property (
    tx_state_ff == TX_GAP |-> !tx_fs_ff ##1 !tx_pins_o.fs)
    else $error("sync high in gap");
  a_gap_entered: assert property (tx_run && fall_tick && tx_state_ff == TX_SHIFT
    && tx_cnt_ff == 5'h00 |=> tx_state_ff == TX_GAP) else $error("no idle bits after word");
  a_idle_when_off: assert property (!port_on |=> tx_state_ff == TX_IDLE)
    else $error("shifting with port off");
endmodule
`default_nettype wire

// ### verilog/ssi_pkg.sv
`default_nettype none
package ssi_pkg;
  // ----------------------------------------
  // Widths and register offsets
  // ----------------------------------------
  localparam int          DATA_W  = 24;
  localparam int          ADDR_W  = 16;
  localparam logic [15:0] A_PCC   = 16'hFFE1; // port_c_control
  localparam logic [15:0] A_PDIR  = 16'hFFE3; // port_c_direction
  localparam logic [15:0] A_PDAT  = 16'hFFE5; // port_c_pin_data
  localparam logic [15:0] A_CTLA  = 16'hFFEC; // serial_control_a
  localparam logic [15:0] A_CTLB  = 16'hFFED; // serial_control_b
  localparam logic [15:0] A_STAT  = 16'hFFEE; // serial_status
  localparam logic [15:0] A_DATA  = 16'hFFEF; // serial_tx_rx_data
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTLA_PRE_LSB = 0;  // Half bit period - 1, 8 bits
  localparam int CTLA_DIV_LSB = 8;  // frame_divide_ratio, 5 bits
  localparam int CTLA_WL_LSB  = 13; // Word length code, 2 bits
  localparam int CTLB_FSD     = 4;  // frame_sync_pin_direction
  localparam int CTLB_BIT_CLOCK_DIRECTION    = 5;  // bit_clock_direction
  localparam int CTLB_SYN     = 9;  // Synchronous clocking
  localparam int CTLB_GCK     = 10; // Gated clock
  localparam int CTLB_NET     = 11; // Network mode
  localparam int CTLB_RE      = 12; // receiver_enable
  localparam int CTLB_TE      = 13; // transmitter_enable
  localparam int PCC_ON       = 8;  // Serial port pins on
  localparam int STAT_TDE     = 6;  // transmit_empty_flag
  localparam int STAT_RDF     = 7;  // receive_full_flag
  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [23:0] REG_RST  = 24'h000000;
  localparam logic [4:0]  DIV_OND  = 5'h00;
  localparam logic [1:0]  GAP_BITS = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h1,
    TX_SHIFT = 3'h2,
    TX_GAP   = 3'h4
  } tx_state_t;
  typedef struct packed {
    logic sck;    // Transmit bit clock
    logic sck_oe;
    logic fs;     // Transmit frame sync
    logic fs_oe;
    logic txd;    // Serial data out
    logic txd_oe;
  } tx_pins_t;
  typedef struct packed {
    logic sck; // Receive bit clock
    logic fs;  // Receive frame sync
    logic rxd; // Serial data in
  } rx_pins_t;
  // Word length code to bit count
  function automatic logic [4:0] word_bits(input logic [1:0] wl);
    case (wl)
      2'h0:    word_bits = 5'h08;
      2'h1:    word_bits = 5'h0C;
      2'h2:    word_bits = 5'h10;
      default: word_bits = 5'h18;
    endcase
  endfunction
endpackage
`default_nettype wire
